// >>> core/arso_pkg.sv
package arso_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_REQ  = 5;
    localparam int NUM_SHOT = 5;

    // ------------------------------------------------------------
    // Register map (word offsets as byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SHOT_OFS   = 8'h08;

    // Control register fields
    localparam int CTRL_MODE_BIT   = 0;
    localparam int CTRL_USEONF_BIT = 1;
    localparam int CTRL_LASTSHOT_LSB = 4;
    localparam int CTRL_LASTSHOT_W   = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0050;

    // Status register fields
    localparam int ST_ENABLED  = 0;
    localparam int ST_DISABLED = 1;
    localparam int ST_ARMED    = 2;
    localparam int ST_ACTIVE   = 3;
    localparam int ST_INHIBIT  = 4;
    localparam int ST_LOCKED   = 5;
    localparam int ST_INFLIGHT = 6;
    localparam int ST_DEAD     = 7;
    localparam int ST_ARC      = 8;
    localparam int ST_RECLAIM  = 9;
    localparam int ST_DONE     = 10;
    localparam int ST_FINAL    = 11;
    localparam int ST_PSLOCK   = 12;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ARMED,
        MODE_ACTIVE,
        MODE_INHIBIT,
        MODE_LOCKED
    } arso_mode_type;

    typedef struct packed {
        logic                dead_run;
        logic                arc_run;
        logic                reclaim_run;
        logic                lockout_run;
        logic                shot_closed;
        logic                final_trip_done;
        logic                fault;
        logic                inhibit;
        logic [2:0]          shot_num;
    } arso_core_type;

    typedef struct packed {
        logic                enabled;
        logic                disabled;
        logic                armed;
        logic                active;
        logic                inhibit;
        logic                locked;
        logic                inflight;
        logic                dead;
        logic                arc;
        logic                reclaim;
        logic                done;
        logic                final_trip;
        logic                pslock;
        logic [NUM_REQ-1:0]  req_on;
        logic [NUM_SHOT-1:0] shot_on;
    } arso_ind_type;

endpackage

// >>> core/arso_status.sv
module arso_status (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    // Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Recloser pins and core state
    input  wire logic                          onoff_pin,
    input  wire logic                          critical_pin,
    input  wire logic                          manual_reset_pin,
    input  wire logic [arso_pkg::NUM_REQ-1:0]  reclose_request_pin,
    input  wire arso_pkg::arso_core_type       core_i,
    // Indications
    output arso_pkg::arso_ind_type             ind_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = arso_pkg::NUM_REQ + 3;
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_sync_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {reclose_request_pin, manual_reset_pin, critical_pin, onoff_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    wire logic                         onoff_s  = pin_sync_q[0];
    wire logic                         crit_s   = pin_sync_q[1];
    wire logic                         mreset_s = pin_sync_q[2];
    wire logic [arso_pkg::NUM_REQ-1:0] req_s    = pin_sync_q[NPIN-1:3];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    wire logic   mode_en  = ctrl_q[arso_pkg::CTRL_MODE_BIT];
    wire logic   use_onf  = ctrl_q[arso_pkg::CTRL_USEONF_BIT];
    wire logic [2:0] last_shot =
        ctrl_q[arso_pkg::CTRL_LASTSHOT_LSB +: arso_pkg::CTRL_LASTSHOT_W];

    // On/off input only counts when marked in use
    wire logic enabled_d  = mode_en & (~use_onf | onoff_s);
    wire logic disabled_d = use_onf & ~onoff_s;

    // ------------------------------------------------------------
    // Request priority
    // ------------------------------------------------------------
    function automatic logic [arso_pkg::NUM_REQ-1:0] prio_pick(input logic [arso_pkg::NUM_REQ-1:0] r);
        logic [arso_pkg::NUM_REQ-1:0] p;
        p = '0;
        for (int i = arso_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (r[i]) begin
                p = '0;
                p[i] = 1'b1;
            end
        end
        return p;
    endfunction

    wire logic [arso_pkg::NUM_REQ-1:0] req_pick = prio_pick(req_s);

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    arso_pkg::arso_mode_type      mode_q;
    arso_pkg::arso_mode_type      mode_d;
    logic [arso_pkg::NUM_REQ-1:0] req_latch_q;
    logic                         pslock_q;
    logic                         done_q;
    logic                         final_q;

    function automatic logic mode_is(input arso_pkg::arso_mode_type m, input arso_pkg::arso_mode_type want);
        return m == want;
    endfunction

    wire logic in_armed    = mode_is(mode_q, arso_pkg::MODE_ARMED);
    wire logic in_active   = mode_is(mode_q, arso_pkg::MODE_ACTIVE);
    wire logic in_inhibit  = mode_is(mode_q, arso_pkg::MODE_INHIBIT);
    wire logic in_locked   = mode_is(mode_q, arso_pkg::MODE_LOCKED);
    wire logic stay_active = mode_is(mode_d, arso_pkg::MODE_ACTIVE);

    // Sequencer quiet: no dead, arc or reclaim timer counting and breaker not just closed
    wire logic seq_idle   = ~core_i.reclaim_run & ~core_i.dead_run & ~core_i.arc_run & ~core_i.shot_closed;
    wire logic seq_start  = in_armed & core_i.fault & (|req_pick);
    wire logic pslock_set = core_i.lockout_run & core_i.fault;
    wire logic pslock_clr = mreset_s;
    wire logic last_close = core_i.shot_closed & (core_i.shot_num == last_shot);
    wire logic done_clr   = core_i.final_trip_done | ~core_i.reclaim_run;
    wire logic final_clr  = mreset_s;
    wire logic unlock_ok  = mreset_s & ~pslock_q;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            arso_pkg::MODE_ARMED: begin
                if (pslock_set) begin
                    mode_d = arso_pkg::MODE_LOCKED;
                end else if (core_i.inhibit) begin
                    mode_d = arso_pkg::MODE_INHIBIT;
                end else if (seq_start) begin
                    mode_d = arso_pkg::MODE_ACTIVE;
                end
            end
            arso_pkg::MODE_ACTIVE: begin
                if (core_i.final_trip_done) begin
                    mode_d = arso_pkg::MODE_LOCKED;
                end else if (seq_idle) begin
                    mode_d = arso_pkg::MODE_ARMED;
                end
            end
            arso_pkg::MODE_INHIBIT: begin
                if (~core_i.inhibit) begin
                    mode_d = arso_pkg::MODE_ARMED;
                end
            end
            arso_pkg::MODE_LOCKED: begin
                if (unlock_ok) begin
                    mode_d = arso_pkg::MODE_ARMED;
                end
            end
        endcase
        // A latched lockout holds locked from any mode, not only from ready
        if (pslock_set | pslock_q) begin
            mode_d = arso_pkg::MODE_LOCKED;
        end
        // Critical request beats every other transition
        if (crit_s) begin
            mode_d = arso_pkg::MODE_LOCKED;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_q <= arso_pkg::MODE_ARMED;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Request that started the sequence, held while running
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            req_latch_q <= '0;
        end else if (seq_start) begin
            req_latch_q <= req_pick;
        end else if (~stay_active) begin
            req_latch_q <= '0;
        end
    end

    // Set wins over a manual reset in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pslock_q <= 1'b0;
        end else if (pslock_set) begin
            pslock_q <= 1'b1;
        end else if (pslock_clr) begin
            pslock_q <= 1'b0;
        end
    end

    // Sequence done held until final trip or reclaim expiry
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else if (last_close) begin
            done_q <= 1'b1;
        end else if (done_clr) begin
            done_q <= 1'b0;
        end
    end

    // Final trip stays shown until someone resets by hand
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            final_q <= 1'b0;
        end else if (core_i.final_trip_done) begin
            final_q <= 1'b1;
        end else if (final_clr) begin
            final_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shot decode
    // ------------------------------------------------------------
    function automatic logic [arso_pkg::NUM_SHOT-1:0] shot_dec(input logic [2:0] n);
        logic [arso_pkg::NUM_SHOT-1:0] s;
        s = '0;
        for (int i = 0; i < arso_pkg::NUM_SHOT; i++)
            if (n == 3'(i + 1))
                s[i] = 1'b1;
        return s;
    endfunction


    // ------------------------------------------------------------
    // Indication register; nothing here drives the breaker
    // ------------------------------------------------------------
    arso_pkg::arso_ind_type ind_d;
    always_comb begin
        ind_d            = '0;
        ind_d.enabled    = enabled_d;
        ind_d.disabled   = disabled_d;
        ind_d.armed      = enabled_d & in_armed;
        ind_d.active     = enabled_d & in_active;
        ind_d.inhibit    = enabled_d & in_inhibit;
        ind_d.locked     = enabled_d & in_locked;
        ind_d.inflight   = enabled_d & in_active & core_i.dead_run;
        ind_d.dead       = enabled_d & in_active & core_i.dead_run;
        ind_d.arc        = enabled_d & core_i.arc_run;
        ind_d.reclaim    = enabled_d & core_i.reclaim_run;
        ind_d.done       = enabled_d & done_q;
        ind_d.final_trip = enabled_d & final_q;
        ind_d.pslock     = enabled_d & pslock_q;
        ind_d.req_on     = enabled_d & in_active ? req_latch_q : '0;
        ind_d.shot_on    = enabled_d & in_active ? shot_dec(core_i.shot_num) : '0;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst)
            ind_o <= '0;
        else
            ind_o <= ind_d;
    end

    // ------------------------------------------------------------
    // Wishbone slave, one wait state, ack for any address
    // ------------------------------------------------------------
    wire logic wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic sel_ctrl  = (wb_adr_i == arso_pkg::CTRL_OFS);
    wire logic sel_stat  = (wb_adr_i == arso_pkg::STATUS_OFS);
    wire logic sel_shot  = (wb_adr_i == arso_pkg::SHOT_OFS);
    wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    logic [31:0] stat_word;
    logic [31:0] shot_word;

    // Status bits placed by name so the map lives in one place
    always_comb begin
        stat_word                         = '0;
        stat_word[arso_pkg::ST_ENABLED]  = ind_o.enabled;
        stat_word[arso_pkg::ST_DISABLED] = ind_o.disabled;
        stat_word[arso_pkg::ST_ARMED]    = ind_o.armed;
        stat_word[arso_pkg::ST_ACTIVE]   = ind_o.active;
        stat_word[arso_pkg::ST_INHIBIT]  = ind_o.inhibit;
        stat_word[arso_pkg::ST_LOCKED]   = ind_o.locked;
        stat_word[arso_pkg::ST_INFLIGHT] = ind_o.inflight;
        stat_word[arso_pkg::ST_DEAD]     = ind_o.dead;
        stat_word[arso_pkg::ST_ARC]      = ind_o.arc;
        stat_word[arso_pkg::ST_RECLAIM]  = ind_o.reclaim;
        stat_word[arso_pkg::ST_DONE]     = ind_o.done;
        stat_word[arso_pkg::ST_FINAL]    = ind_o.final_trip;
        stat_word[arso_pkg::ST_PSLOCK]   = ind_o.pslock;
    end

    // Shot bits low, request bits right above them
    always_comb begin
        shot_word                                          = '0;
        shot_word[arso_pkg::NUM_SHOT-1:0]                  = ind_o.shot_on;
        shot_word[arso_pkg::NUM_SHOT +: arso_pkg::NUM_REQ] = ind_o.req_on;
    end

    wire logic [31:0] rd_mux = sel_ctrl ? ctrl_q : sel_stat ? stat_word : sel_shot ? shot_word : 32'h0;
    wire logic        wr_ctrl = wb_req & wb_we_i & sel_ctrl;
    wire logic        rd_take = wb_req & ~wb_we_i;

    // Every request is acked, mapped or not, so a stray access never hangs the bus
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Read data held until the next read
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0;
        end else if (rd_take) begin
            wb_dat_o <= rd_mux;
        end
    end

    // Byte lanes masked; status and shot words are read-only
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q <= arso_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

endmodule // arso_status

// >>> sim/arso_seq_model.sv
module arso_seq_model (
    // Clock and scenario step
    input wire logic                mclk,
    input wire logic [2:0]          phase,
    input wire logic [2:0]          shot,
    // Sequencer state seen by the block
    output arso_pkg::arso_core_type core_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Flags per step: dead, arc, reclaim, lockout, closed, final, fault, inhibit
    // Dead step carries the fault too, else no sequence could ever start
    localparam logic [7:0] STEP [8] = '{8'h00, 8'h82, 8'h40, 8'h20, 8'h28, 8'h04, 8'h01, 8'h12};
    initial core_o = '0;
    // One timer at a time, as a real sequence never overlaps them
    always @(posedge mclk) core_o <= {STEP[phase], shot};
endmodule // arso_seq_model

// >>> sim/arso_status_properties.sv
module arso_status_properties (
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    sys_rst,
    // Bus handshake and pins
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_ack_o,
    input wire logic                    critical_pin,
    // Core state and indications
    input wire arso_pkg::arso_core_type core_i,
    input wire arso_pkg::arso_ind_type  ind_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic [3:0] mode_w = {ind_o.armed, ind_o.active, ind_o.inhibit, ind_o.locked};
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_timing_a: assert property (s_take |=> s_ack_once)
        else $error("ack not one cycle after request");
    mode_onehot_a: assert property (ind_o.enabled |-> $onehot(mode_w))
        else $error("mode indications not one-hot");
    mode_off_a: assert property (!ind_o.enabled |-> mode_w == 4'h0)
        else $error("mode shown while disabled");
    dead_pair_a: assert property (ind_o.dead == ind_o.inflight)
        else $error("dead and in-progress differ");
    shot_req_onehot_a: assert property ($onehot0(ind_o.shot_on) && $onehot0(ind_o.req_on))
        else $error("several shots or requests shown");
    arc_follow_a: assert property (ind_o.enabled && core_i.arc_run |-> ##[1:2] ind_o.arc)
        else $error("arc timer not shown");
    reclaim_follow_a: assert property (ind_o.enabled && core_i.reclaim_run |-> ##[1:2] ind_o.reclaim)
        else $error("reclaim timer not shown");
    critical_lock_a: assert property (critical_pin [*5] ##0 ind_o.enabled |-> ind_o.locked)
        else $error("critical request did not lock");
    pslock_lock_a: assert property (ind_o.pslock && ind_o.enabled |-> ##[0:1] ind_o.locked)
        else $error("post-success lockout not locked");
endmodule // arso_status_properties

bind arso_status arso_status_properties u_props (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .critical_pin, .core_i, .ind_o);

// >>> sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        wb_ack_o, onoff_pin = 1'b0, critical_pin = 1'b0, manual_reset_pin = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [4:0]  req = 5'h00, r;
    logic [2:0]  phase = 3'h0, shot = 3'h1;
    arso_pkg::arso_core_type core_i;
    arso_pkg::arso_ind_type  ind_o;
    integer      seed = 32'habed;
    int          n_mismatch = 0, n_checks = 0;

    always #5 mclk = ~mclk;

    arso_status dut (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .onoff_pin, .critical_pin, .manual_reset_pin,
        .reclose_request_pin(req), .core_i, .ind_o);
    arso_seq_model seq (.mclk, .phase, .shot, .core_o(core_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    // Five cycles cover the two sync stages, the mode register and the output register
    task automatic go(input logic [2:0] p, input logic m);
        phase <= p;
        manual_reset_pin <= m;
        repeat (5) @(posedge mclk);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        wb(1'b0, arso_pkg::CTRL_OFS, 32'h0);
        check(rd, arso_pkg::CTRL_RESET);
        check(32'(ind_o), 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, arso_pkg::CTRL_OFS, 32'h51);
        wb(1'b1, arso_pkg::STATUS_OFS, 32'hffff_ffff);
        go(3'h0, 1'b0);
        wb(1'b0, arso_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h5);
        wb(1'b1, arso_pkg::CTRL_OFS, 32'h53);
        go(3'h0, 1'b0);
        check(32'({ind_o.enabled, ind_o.disabled}), 32'h1);
        onoff_pin <= 1'b1;
        go(3'h0, 1'b0);
        check(32'({ind_o.enabled, ind_o.disabled}), 32'h2);
        for (int k = 0; k < 8; k++) begin
            r = (k == 0) ? 5'h1f : 5'($random(seed)) | 5'h10;
            shot <= 3'(k % 5 + 1);
            req <= r;
            go(3'h1, 1'b0);
            check(32'({ind_o.dead, ind_o.inflight, ind_o.active}), 32'h7);
            check(32'(ind_o.shot_on), 32'(5'h01 << (k % 5)));
            check(32'(ind_o.req_on), 32'(r & (~r + 5'h01)));
            go(3'h2, 1'b0);
            check(32'(ind_o.arc), 32'h1);
            go(3'h3, 1'b0);
            check(32'(ind_o.reclaim), 32'h1);
            req <= 5'h00;
            go(3'h0, 1'b0);
        end
        shot <= 3'h5;
        go(3'h4, 1'b0);
        check(32'(ind_o.done), 32'h1);
        go(3'h5, 1'b0);
        check(32'({ind_o.final_trip, ind_o.done}), 32'h2);
        go(3'h0, 1'b1);
        go(3'h6, 1'b0);
        check(32'(ind_o.inhibit), 32'h1);
        go(3'h0, 1'b0);
        go(3'h7, 1'b0);
        check(32'({ind_o.pslock, ind_o.locked}), 32'h3);
        go(3'h0, 1'b1);
        go(3'h0, 1'b0);
        check(32'(ind_o.armed), 32'h1);
        critical_pin <= 1'b1;
        go(3'h0, 1'b0);
        check(32'(ind_o.locked), 32'h1);
        critical_pin <= 1'b0;
        go(3'h0, 1'b1);
        wb(1'b1, arso_pkg::CTRL_OFS, 32'h50);
        go(3'h0, 1'b0);
        check(32'(ind_o.enabled), 32'h0);
        end_of_test();
    end
endmodule // testbench
